// ===== logic/rpm_consts.vh
// Constants for the reset and power-mode sequencer
`ifndef RPM_CONSTS_VH
`define RPM_CONSTS_VH

// ==========================================================
// Register offsets
`define RPM_ADDR_W          4
`define RPM_OFF_PWRCTL      4'h0
`define RPM_OFF_STATUS      4'h1
`define RPM_OFF_SP          4'h2
`define RPM_OFF_DATA_POINTER_LO     4'h3
`define RPM_OFF_DATA_POINTER_HI     4'h4
`define RPM_OFF_PC_LO       4'h5
`define RPM_OFF_PC_HI       4'h6
`define RPM_OFF_PORT_LATCH  4'h7
`define RPM_OFF_RAM_FLAG    4'h8

// ==========================================================
// Power control fields
`define RPM_BIT_IDLE        0
`define RPM_BIT_PDOWN       1
`define RPM_BIT_GF0         2
`define RPM_BIT_GF1         3

// ==========================================================
// Reset values
`define RPM_RST_SFR         8'h00
`define RPM_RST_PORT        8'hff
`define RPM_RST_SP          8'h07
`define RPM_RST_WORD        16'h0000

// ==========================================================
// Timing
`define RPM_OSC_PER_MC      12
`define RPM_S5P2_PHASE      4'h9
`define RPM_PORT_HOLD_OSC   19
`define RPM_RST_MIN_MC      2

`endif

// ===== logic/rpm_sync.v
// Two-stage synchroniser for the reset pin
`timescale 1ns/1ps
module rpm_sync (
    // Clock and reset
    input  wire mclk,
    input  wire sys_rst,
    // Data
    input  wire async_in,
    output reg  sync_out
);
    reg meta;

    // ==========================================================
    // Synchroniser; first stage feeds only the second
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ===== logic/rpm_phase.v
// Machine-cycle phase counter, one phase per oscillator period
`timescale 1ns/1ps
`include "rpm_consts.vh"
module rpm_phase (
    // Clock and reset
    input  wire       mclk,
    input  wire       sys_rst,
    // Control
    input  wire       osc_run,
    // Phase
    output reg  [3:0] phase,
    output wire       s5p2
);
    // ==========================================================
    // Counter; frozen when the oscillator is stopped
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= 4'h0;
        end else if (osc_run) begin
            if (phase == `RPM_OSC_PER_MC - 1)
                phase <= 4'h0;
            else
                phase <= phase + 4'h1;
        end
    end

    assign s5p2 = osc_run && (phase == `RPM_S5P2_PHASE);
endmodule

// ===== logic/rpm_core.v
// Reset and power-mode sequencer top level
`timescale 1ns/1ps
`include "rpm_consts.vh"

module rpm_core (
    // Clock and reset
    input  wire       mclk,
    input  wire       sys_rst,
    // Reset pin
    input  wire       rst_pin,
    // Register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Core side
    input  wire       irq_enabled,
    input  wire       ext_mem_mode,
    input  wire       core_ale,
    input  wire       core_program_store_strobe,
    input  wire       ram_req,
    output wire       cpu_clk_en,
    output wire       periph_clk_en,
    output wire       osc_run,
    output wire       ram_grant,
    output reg        sfr_reset,
    output wire       port_reset,
    // Bus strobes and port control
    output wire       ale_out,
    output wire       program_store_strobe_out,
    output wire       port0_float,
    output wire       port2_addr_en,
    output wire       port_freeze
);
    // ==========================================================
    // State machine
    localparam [3:0] ST_RUN   = 4'b0001;
    localparam [3:0] ST_IDLE  = 4'b0010;
    localparam [3:0] ST_PDOWN = 4'b0100;
    localparam [3:0] ST_RESET = 4'b1000;

    reg  [3:0] state;
    reg  [3:0] next_state;
    reg        idle_bit;
    reg        pdown_bit;
    reg        gflag0;
    reg        gflag1;
    reg  [7:0] stack_ptr;
    reg [15:0] data_pointer;
    reg [15:0] prog_counter;
    reg  [7:0] port_latch;
    reg        rst_sampled;
    reg  [4:0] hold_cnt;
    reg  [1:0] rst_mc_cnt;
    reg        ram_block;
    reg        idle_entered;
    wire       rst_sync;
    wire       s5p2;
    wire       pin_idle_clr;
    wire       run_wr;
    wire       pwrctl_wr;

    // ==========================================================
    // Decoding helper
    function is_reg;
        input [3:0] addr;
        input [3:0] off;
        begin
            is_reg = (addr == off);
        end
    endfunction

    // Pin is asynchronous; two flops cost up to two clocks of reset latency
    rpm_sync u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .async_in (rst_pin),
        .sync_out (rst_sync)
    );

    // Phase count stops with the oscillator, so in power-down samples are taken only while the reset pin restarts it
    rpm_phase u_phase (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .osc_run (osc_run),
        .phase   (),
        .s5p2    (s5p2)
    );

    // Oscillator runs unless power-down; reset pin restarts it
    assign osc_run = (state != ST_PDOWN) || rst_sync;

    // ==========================================================
    // Reset pin sampling once per machine cycle
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sampled <= 1'b0;
        end else if (s5p2) begin
            rst_sampled <= rst_sync;
        end
    end

    // Pin level clears idle without waiting for the sampling point
    assign pin_idle_clr = rst_sync;

    // Port hold count: 19 oscillator periods after a high sample
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt <= 5'h00;
        end else if (!rst_sampled) begin
            hold_cnt <= 5'h00;
        end else if (hold_cnt != `RPM_PORT_HOLD_OSC) begin
            hold_cnt <= hold_cnt + 5'h01;
        end
    end
    assign port_reset = rst_sampled && (hold_cnt == `RPM_PORT_HOLD_OSC);

    // Consecutive machine cycles with reset sampled high
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_mc_cnt <= 2'h0;
        end else if (s5p2) begin
            if (!rst_sync)
                rst_mc_cnt <= 2'h0;
            else if (rst_mc_cnt != `RPM_RST_MIN_MC)
                rst_mc_cnt <= rst_mc_cnt + 2'h1;
        end
    end

    // ==========================================================
    // Mode state machine
    // Power-down is tested before idle so both bits together stop the oscillator
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (rst_mc_cnt == `RPM_RST_MIN_MC)
                    next_state = ST_RESET;
                else if (pdown_bit)
                    next_state = ST_PDOWN;
                else if (idle_bit)
                    next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (!idle_bit)
                    next_state = ST_RUN;
            end
            ST_PDOWN: begin
                if (rst_mc_cnt == `RPM_RST_MIN_MC)
                    next_state = ST_RESET;
            end
            ST_RESET: begin
                if (!rst_sampled)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    // Internal reset algorithm active while in reset state
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            sfr_reset <= 1'b1;
        else
            sfr_reset <= (next_state == ST_RESET);
    end

    // RAM blocked from idle exit by reset until the reset algorithm takes over
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ram_block    <= 1'b0;
            idle_entered <= 1'b0;
        end else begin
            idle_entered <= (state == ST_IDLE);
            if (state == ST_RESET)
                ram_block <= 1'b0;
            else if (state == ST_IDLE && pin_idle_clr)
                ram_block <= 1'b1;
            else if (s5p2 && !rst_sync)
                ram_block <= 1'b0; // Pulse too short to reset must not lock RAM out
        end
    end
    // RAM has no reset path here, only access gating
    assign ram_grant = ram_req && !ram_block && (state == ST_RUN);

    // ==========================================================
    // Write decode; writes land only in run, so software cannot change a register in idle
    assign run_wr    = reg_wr && (state == ST_RUN);
    assign pwrctl_wr = run_wr && is_reg(reg_addr, `RPM_OFF_PWRCTL);

    // ==========================================================
    // Power control and reset-loaded registers
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_bit     <= 1'b0;
            pdown_bit    <= 1'b0;
            gflag0       <= 1'b0;
            gflag1       <= 1'b0;
            stack_ptr    <= `RPM_RST_SP;
            data_pointer <= `RPM_RST_WORD;
            prog_counter <= `RPM_RST_WORD;
            port_latch   <= `RPM_RST_PORT;
        end else if (state == ST_RESET) begin
            idle_bit     <= 1'b0;
            pdown_bit    <= 1'b0;
            gflag0       <= 1'b0;
            gflag1       <= 1'b0;
            stack_ptr    <= `RPM_RST_SP;
            data_pointer <= `RPM_RST_WORD;
            prog_counter <= `RPM_RST_WORD;
            if (port_reset)
                port_latch <= `RPM_RST_PORT;
        end else begin
            // Hardware clears beat a software write in the same cycle
            if (pin_idle_clr || (state == ST_IDLE && irq_enabled))
                idle_bit <= 1'b0;
            else if (pwrctl_wr)
                idle_bit <= reg_wdata[`RPM_BIT_IDLE];
            if (pwrctl_wr) begin
                pdown_bit <= reg_wdata[`RPM_BIT_PDOWN];
                gflag0    <= reg_wdata[`RPM_BIT_GF0];
                gflag1    <= reg_wdata[`RPM_BIT_GF1];
            end
            if (run_wr) begin
                if (is_reg(reg_addr, `RPM_OFF_SP))
                    stack_ptr <= reg_wdata;
                if (is_reg(reg_addr, `RPM_OFF_DATA_POINTER_LO))
                    data_pointer[7:0] <= reg_wdata;
                if (is_reg(reg_addr, `RPM_OFF_DATA_POINTER_HI))
                    data_pointer[15:8] <= reg_wdata;
                if (is_reg(reg_addr, `RPM_OFF_PC_LO))
                    prog_counter[7:0] <= reg_wdata;
                if (is_reg(reg_addr, `RPM_OFF_PC_HI))
                    prog_counter[15:8] <= reg_wdata;
                if (is_reg(reg_addr, `RPM_OFF_PORT_LATCH))
                    port_latch <= reg_wdata;
            end
        end
    end

    // ==========================================================
    // Read port, data one cycle after the strobe
    // Unmapped offsets read as zero so software sees no stale value
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RPM_OFF_PWRCTL:     reg_rdata <= {4'h0, gflag1, gflag0, pdown_bit, idle_bit};
                `RPM_OFF_STATUS:     reg_rdata <= {ram_block, rst_sampled, 2'h0, state};
                `RPM_OFF_SP:         reg_rdata <= stack_ptr;
                `RPM_OFF_DATA_POINTER_LO:    reg_rdata <= data_pointer[7:0];
                `RPM_OFF_DATA_POINTER_HI:    reg_rdata <= data_pointer[15:8];
                `RPM_OFF_PC_LO:      reg_rdata <= prog_counter[7:0];
                `RPM_OFF_PC_HI:      reg_rdata <= prog_counter[15:8];
                `RPM_OFF_PORT_LATCH: reg_rdata <= port_latch;
                `RPM_OFF_RAM_FLAG:   reg_rdata <= {7'h00, idle_entered};
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Clock gating and pin states
    // Peripherals keep their clock in idle so an interrupt can still wake the core
    assign cpu_clk_en    = (state == ST_RUN) || (state == ST_RESET);
    assign periph_clk_en = (state != ST_PDOWN);
    // Strobes high in idle, low in power-down, else from the core
    assign ale_out  = (state == ST_IDLE) ? 1'b1 :
                      (state == ST_PDOWN) ? 1'b0 : core_ale;
    assign program_store_strobe_out = (state == ST_IDLE) ? 1'b1 :
                      (state == ST_PDOWN) ? 1'b0 : core_program_store_strobe;
    assign port0_float   = ext_mem_mode && ((state == ST_IDLE) || (state == ST_PDOWN));
    assign port2_addr_en = ext_mem_mode && (state == ST_IDLE);
    assign port_freeze   = (state == ST_IDLE) || (state == ST_PDOWN);
endmodule

// ===== sim/rpm_core_chk.sv
// Port checker for the reset and power-mode sequencer
`timescale 1ns/1ps
// ==========================================================
// Checker
module rpm_core_chk (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Inputs
    input wire rst_pin,
    input wire irq_enabled,
    input wire ext_mem_mode,
    input wire ram_req,
    // Outputs
    input wire cpu_clk_en,
    input wire periph_clk_en,
    input wire ram_grant,
    input wire sfr_reset,
    input wire port_reset,
    input wire ale_out,
    input wire program_store_strobe_out,
    input wire port0_float,
    input wire port2_addr_en,
    input wire port_freeze
);
    // Mode decode from the pins alone
    wire idle = port_freeze & periph_clk_en;
    wire pdn  = port_freeze & ~periph_clk_en;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_idle_strobes: assert property (idle |-> ale_out && program_store_strobe_out && !cpu_clk_en)
        else $error("strobes or cpu clock wrong in idle");
    a_pdown_pins: assert property (pdn |-> !ale_out && !program_store_strobe_out && !port2_addr_en)
        else $error("strobes or port 2 wrong in power-down");
    a_bus_float: assert property (port0_float == (ext_mem_mode && port_freeze))
        else $error("port 0 float wrong");
    a_pdown_hold: assert property ((pdn && !rst_pin)[*6] |=> pdn)
        else $error("power-down left without reset");
    a_irq_wake: assert property (idle && irq_enabled |-> ##[1:4] !idle)
        else $error("interrupt did not end idle");
    a_pin_wake: assert property (idle && rst_pin |-> ##[1:4] !idle)
        else $error("reset pin did not end idle");
    a_ram_block: assert property (ram_grant |-> ram_req && !port_freeze && !sfr_reset)
        else $error("ram granted while blocked");
    a_port_delay: assert property ($rose(rst_pin) && !port_reset |=> !port_reset[*8])
        else $error("ports reset too early");
endmodule

bind rpm_core rpm_core_chk u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .rst_pin(rst_pin), .irq_enabled(irq_enabled),
    .ext_mem_mode(ext_mem_mode), .ram_req(ram_req), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .ram_grant(ram_grant), .sfr_reset(sfr_reset),
    .port_reset(port_reset), .ale_out(ale_out), .program_store_strobe_out(program_store_strobe_out),
    .port0_float(port0_float), .port2_addr_en(port2_addr_en), .port_freeze(port_freeze)
);

// ===== sim/rpm_rst_src.sv
// External reset source model driving the reset pin
`timescale 1ns/1ps
// ==========================================================
// Reset source
module rpm_rst_src (
    // Clock
    input  wire       mclk,
    // Command
    input  wire       go,
    input  wire [7:0] len,
    // Reset pin
    output reg        rst_pin
);
    reg [7:0] left;

    // Pin has a pull-down, so released means low
    initial begin
        rst_pin = 1'b0;
        left = 8'h00;
    end

    // Holds the pin high exactly len cycles, 24 or more for a real reset
    always @(posedge mclk) begin
        if (go) begin
            left <= len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
        rst_pin <= go || (left > 8'h01);
    end
endmodule

// ===== sim/tb_reset_and_power_mode_control.sv
// Testbench for the reset and power-mode sequencer
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb_reset_and_power_mode_control;
    logic       mclk, sys_rst, rst_pin, reg_wr, reg_rd, irq_enabled, ext_mem_mode;
    logic       core_ale, core_program_store_strobe, ram_req, go, cpu_clk_en, periph_clk_en, osc_run;
    logic       ram_grant, sfr_reset, port_reset, ale_out, program_store_strobe_out, port0_float;
    logic       port2_addr_en, port_freeze;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, plen, pins;
    logic [3:0] ra[8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
    logic [7:0] rv[8] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    integer     n_mismatch = 0, comparisons = 0, n, i;

    assign pins = {cpu_clk_en, periph_clk_en, ale_out, program_store_strobe_out,
                   port0_float, port2_addr_en, port_freeze, osc_run};

    rpm_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .rst_pin(rst_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_enabled(irq_enabled), .ext_mem_mode(ext_mem_mode), .core_ale(core_ale),
        .core_program_store_strobe(core_program_store_strobe), .ram_req(ram_req), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_run(osc_run), .ram_grant(ram_grant),
        .sfr_reset(sfr_reset), .port_reset(port_reset), .ale_out(ale_out),
        .program_store_strobe_out(program_store_strobe_out), .port0_float(port0_float), .port2_addr_en(port2_addr_en),
        .port_freeze(port_freeze));
    rpm_rst_src u_src (.mclk(mclk), .go(go), .len(plen), .rst_pin(rst_pin));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the read edge
    task rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask

    task pulse(input logic [7:0] l);
        @(posedge mclk);
        go <= 1'b1;
        plen <= l;
        @(posedge mclk);
        go <= 1'b0;
    endtask

    // Wait for the internal reset algorithm to start and finish
    task settle;
        n = 0;
        while (sfr_reset !== 1'b1 && n < 80) begin
            @(posedge mclk);
            n++;
        end
        while (sfr_reset !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        chk("reset_done", 8'h01, {7'h00, n < 200});
    endtask

    task results;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        results;
    end

    initial begin
        {sys_rst, ext_mem_mode, ram_req} = 3'b111;
        {reg_wr, reg_rd, irq_enabled, core_ale, core_program_store_strobe, go} = 6'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        plen = 8'h00;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        for (i = 0; i < 8; i++) rd(ra[i], rv[i], "reset_value");
        wr(4'h0, 8'h0c);
        rd(4'h0, 8'h0c, "flags");
        // Idle, then woken by an interrupt
        wr(4'h0, 8'h05);
        repeat (2) @(posedge mclk);
        #1 chk("idle_pins", 8'h7f, pins);
        rd(4'h0, 8'h05, "idle_bits");
        rd(4'h1, 8'h02, "idle_state");
        rd(4'h8, 8'h01, "idle_seen");
        @(posedge mclk);
        irq_enabled <= 1'b1;
        repeat (6) @(posedge mclk);
        irq_enabled <= 1'b0;
        #1 chk("irq_wake", 8'hc1, pins);
        rd(4'h0, 8'h04, "irq_clear");
        // Idle ended by the reset pin; ram stays blocked meanwhile
        wr(4'h0, 8'h05);
        repeat (2) @(posedge mclk);
        pulse(8'd24);
        repeat (4) @(posedge mclk);
        #1 chk("pin_wake", 8'hc1, pins);
        chk("ram_block", 8'h00, {7'h00, ram_grant});
        n = 4;
        while (port_reset !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk("port_delay", 8'h01, {7'h00, n >= 19 && n <= 35});
        settle;
        rd(4'h0, 8'h00, "ctl_after_reset");
        rd(4'h2, 8'h07, "stack_after_reset");
        // Too short a pulse must not reset
        wr(4'h0, 8'h08);
        pulse(8'd8);
        repeat (40) @(posedge mclk);
        rd(4'h0, 8'h08, "short_pulse");
        // Both bits together give power-down; interrupts cannot end it
        @(posedge mclk);
        core_ale <= 1'b1;
        core_program_store_strobe <= 1'b1;
        wr(4'h0, 8'h03);
        repeat (2) @(posedge mclk);
        irq_enabled <= 1'b1;
        #1 chk("pdown_pins", 8'h0a, pins);
        repeat (30) @(posedge mclk);
        irq_enabled <= 1'b0;
        #1 chk("pdown_stays", 8'h0a, pins);
        pulse(8'd60);
        settle;
        rd(4'h0, 8'h00, "ctl_after_pdown");
        @(posedge mclk);
        #1 chk("run_pins", 8'hf1, pins);
        chk("ram_open", 8'h01, {7'h00, ram_grant});
        results;
    end
endmodule
